// File: core/reference_switchover_holdover.sv
// Input-loop reference control: dividers, presence monitor, switchover,
// holdover charge-pump control, receiver power gating, Avalon-MM registers.
// Assumes reference clocks and the select pin are asynchronous to mclk and
// slow enough (under mclk/4) to be sampled and edge-detected here.
//
// What this block does
// - Differential receiver off when both inputs are CMOS or input loop powered down.
// - Single-ended buffer off on loop down, own power-down or differential.
// - Secondary divider uses primary ratio unless independent division set.
// - Dedicated fields select CMOS mode; otherwise inputs are differential.
// - Oscillator receiver: two-bit control; feeds feedback divider, doubler.
// - Oscillator receiver powered down while input-loop power-down bit set.
// - Each reference has its own integer divider, ratio 1 to 1023.
// - Presence monitor watches divided references and steers switchover.
// - Manual selection by register bit or by the select pin.
// - Auto mode moves to secondary when primary lost and secondary present.
// - Nonrevertive keeps secondary; back to primary only if secondary lost.
// - Revertive returns to primary as soon as primary comes back.
// - Holdover when neither reference present; loop runs from oscillator.
// - Holdover tristates charge pump unless forced mid-supply configured.
// - Leave holdover when a reference returns; resynchronise to it in auto mode, to the selected reference in manual mode.
// - Configuration bit forces charge pump to half supply during holdover.
// - In auto mode a lone present reference becomes active; the other is backup.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module reference_switchover_holdover #(
	parameter int WINDOW_CYCLES = 16384,
	parameter int EDGE_COUNT    = 4
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [11:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Reference clocks and select pin
	input  wire logic        primary_reference_input,
	input  wire logic        secondary_reference_input,
	input  wire logic        ref_select_pin,
	// Receiver power and oscillator receiver control
	output logic             diff_rx_pd,
	output logic [1:0]       se_buf_pd,
	output logic             osc_rx_pd,
	output logic [1:0]       osc_rx_ctrl,
	// Charge pump and loop status
	output logic             cp_tristate,
	output logic             cp_midsupply,
	output logic             active_secondary,
	output logic             holdover,
	output logic             loop_resync,
	output logic             irq
);

	// Window counter is WIN_W bits wide, hit and miss counters HIT_W bits
	if (WINDOW_CYCLES < 16 || WINDOW_CYCLES > 65535)
	begin : g_bad_window
		$error("WINDOW_CYCLES out of range");
	end
	if (EDGE_COUNT < 1 || EDGE_COUNT > 15)
	begin : g_bad_edges
		$error("EDGE_COUNT out of range");
	end

	localparam logic [refswitch_pkg::WIN_W-1:0] WIN_LAST =
		refswitch_pkg::WIN_W'(WINDOW_CYCLES - 1);
	localparam logic [refswitch_pkg::HIT_W-1:0] EDGES =
		refswitch_pkg::HIT_W'(EDGE_COUNT);

	refswitch_pkg::state_t s_reg;
	refswitch_pkg::state_t s_next;

	logic [1:0] ref_in;
	assign ref_in = {secondary_reference_input, primary_reference_input};

	always_comb
	begin
		logic [9:0]  ratio [2];
		logic [1:0]  rise;
		logic [1:0]  dedge;
		logic [1:0]  pres;
		logic [1:0]  lost;
		logic        sel_sec;
		logic        auto_mode;
		logic        req;
		logic        acc;
		logic [9:0]  idx;
		logic [31:0] wmask;
		logic [31:0] rd;
		logic [refswitch_pkg::IRQ_W-1:0] ev;
		logic [refswitch_pkg::IRQ_W-1:0] clr;
		refswitch_pkg::sw_state_t nst;

		s_next = s_reg;
		ev = '0;
		clr = '0;
		rise = '0;
		dedge = '0;
		lost = '0;
		rd = 32'h0000_0000;
		ratio[0] = refswitch_pkg::DIV_MIN;
		ratio[1] = refswitch_pkg::DIV_MIN;
		pres = 2'b00;
		sel_sec = 1'b0;
		auto_mode = 1'b0;
		req = 1'b0;
		acc = 1'b0;
		idx = 10'h000;
		wmask = 32'h0000_0000;
		nst = s_reg.state;

		// Ratio 0 is not legal; treat as divide by one
		ratio[0] = (s_reg.div_p < refswitch_pkg::DIV_MIN) ?
			refswitch_pkg::DIV_MIN : s_reg.div_p;
		ratio[1] = s_reg.misc[refswitch_pkg::MISC_INDEP_DIV] ?
			s_reg.div_s : s_reg.div_p;
		if (ratio[1] < refswitch_pkg::DIV_MIN)
			ratio[1] = refswitch_pkg::DIV_MIN;

		for (int i = 0; i < 2; i++)
		begin
			s_next.mon[i].sync = {s_reg.mon[i].sync[1:0], ref_in[i]};
			if (s_reg.mon[i].sync[1] == s_reg.mon[i].sync[2]
				&& s_reg.mon[i].sync[2] != s_reg.mon[i].level)
			begin
				s_next.mon[i].level = s_reg.mon[i].sync[2];
				rise[i] = s_reg.mon[i].sync[2];
			end
			// Dedicated integer divider per reference
			if (rise[i])
			begin
				if (s_reg.mon[i].divcnt >= ratio[i] - 10'h001)
				begin
					s_next.mon[i].divcnt = 10'h000;
					dedge[i] = 1'b1;
				end
				else
					s_next.mon[i].divcnt = s_reg.mon[i].divcnt + 10'h001;
			end
			// Monitor looks at divided edges, one verdict per window
			if (dedge[i])
				s_next.mon[i].seen = 1'b1;
			if (s_reg.mon[i].win == WIN_LAST)
			begin
				s_next.mon[i].win = '0;
				s_next.mon[i].seen = dedge[i];
				if (s_reg.mon[i].seen || dedge[i])
				begin
					s_next.mon[i].miss = '0;
					if (s_reg.mon[i].hit + 4'h1 >= EDGES)
						s_next.mon[i].present = 1'b1;
					else
						s_next.mon[i].hit = s_reg.mon[i].hit + 4'h1;
				end
				else
				begin
					s_next.mon[i].hit = '0;
					if (s_reg.mon[i].miss + 4'h1 >= EDGES)
					begin
						s_next.mon[i].present = 1'b0;
						lost[i] = s_reg.mon[i].present;
					end
					else
						s_next.mon[i].miss = s_reg.mon[i].miss + 4'h1;
				end
			end
			else
				s_next.mon[i].win = s_reg.mon[i].win + 16'h0001;
		end
		ev[refswitch_pkg::EV_LOST_P] = lost[0];
		ev[refswitch_pkg::EV_LOST_S] = lost[1];

		// Select pin: stable once second and third stages agree
		s_next.sel_sync = {s_reg.sel_sync[1:0], ref_select_pin};
		if (s_reg.sel_sync[1] == s_reg.sel_sync[2])
			s_next.sel_level = s_reg.sel_sync[2];

		// Switchover control
		pres = {s_reg.mon[1].present, s_reg.mon[0].present};
		auto_mode = s_reg.misc[refswitch_pkg::MISC_AUTO];
		sel_sec = s_reg.misc[refswitch_pkg::MISC_USE_PIN] ?
			s_reg.sel_level : s_reg.misc[refswitch_pkg::MISC_MAN_SEL];
		nst = s_reg.state;
		if (pres == 2'b00)
			nst = refswitch_pkg::HOLDOVER;
		else if (!auto_mode)
			nst = sel_sec ? refswitch_pkg::ON_SECONDARY :
				refswitch_pkg::ON_PRIMARY;
		else
		begin
			unique case (s_reg.state)
				refswitch_pkg::ON_PRIMARY:
					if (!pres[0])
						nst = refswitch_pkg::ON_SECONDARY;
				refswitch_pkg::ON_SECONDARY:
					if (!pres[1])
						nst = refswitch_pkg::ON_PRIMARY;
					else if (s_reg.misc[refswitch_pkg::MISC_REVERT]
						&& pres[0])
						nst = refswitch_pkg::ON_PRIMARY;
				refswitch_pkg::HOLDOVER:
					nst = pres[0] ? refswitch_pkg::ON_PRIMARY :
						refswitch_pkg::ON_SECONDARY;
				default:
					nst = refswitch_pkg::HOLDOVER;
			endcase
		end
		s_next.state = nst;
		ev[refswitch_pkg::EV_SWITCH] = (nst != s_reg.state)
			&& nst != refswitch_pkg::HOLDOVER
			&& s_reg.state != refswitch_pkg::HOLDOVER;
		ev[refswitch_pkg::EV_HOLD_IN] = nst == refswitch_pkg::HOLDOVER
			&& s_reg.state != refswitch_pkg::HOLDOVER;
		ev[refswitch_pkg::EV_HOLD_EX] = nst != refswitch_pkg::HOLDOVER
			&& s_reg.state == refswitch_pkg::HOLDOVER;

		// Avalon-MM: one wait cycle, then a single accept cycle
		req = read || write;
		acc = req && !s_reg.waitreq;
		idx = address[11:2];
		for (int b = 0; b < 4; b++)
			wmask[b*8 +: 8] = {8{byteenable[b]}};
		unique case (idx)
			refswitch_pkg::IDX_RX_CFG:  rd[7:0] = s_reg.rx_cfg;
			refswitch_pkg::IDX_BUF_CFG: rd[7:0] = s_reg.buf_cfg;
			refswitch_pkg::IDX_MISC:    rd[7:0] = s_reg.misc;
			refswitch_pkg::IDX_POWER:   rd[7:0] = s_reg.power;
			refswitch_pkg::IDX_DIV_P:   rd[9:0] = s_reg.div_p;
			refswitch_pkg::IDX_DIV_S:   rd[9:0] = s_reg.div_s;
			refswitch_pkg::IDX_STATUS:
				rd[3:0] = {s_reg.pins.holdover, s_reg.pins.active_sec,
					pres};
			refswitch_pkg::IDX_IRQ_ST:  rd[4:0] = s_reg.irq_st;
			refswitch_pkg::IDX_IRQ_MSK: rd[4:0] = s_reg.irq_msk;
			default:                    rd = 32'h0000_0000;
		endcase
		s_next.waitreq = !(req && s_reg.waitreq);
		if (req && s_reg.waitreq)
			s_next.rdata = rd;
		if (acc && write)
		begin
			unique case (idx)
				refswitch_pkg::IDX_RX_CFG: s_next.rx_cfg =
					(s_reg.rx_cfg & ~wmask[7:0]) | (writedata[7:0] & wmask[7:0]);
				refswitch_pkg::IDX_BUF_CFG: s_next.buf_cfg =
					(s_reg.buf_cfg & ~wmask[7:0]) | (writedata[7:0] & wmask[7:0]);
				refswitch_pkg::IDX_MISC: s_next.misc =
					(s_reg.misc & ~wmask[7:0]) | (writedata[7:0] & wmask[7:0]);
				refswitch_pkg::IDX_POWER: s_next.power =
					(s_reg.power & ~wmask[7:0]) | (writedata[7:0] & wmask[7:0]);
				refswitch_pkg::IDX_DIV_P: s_next.div_p =
					(s_reg.div_p & ~wmask[9:0]) | (writedata[9:0] & wmask[9:0]);
				refswitch_pkg::IDX_DIV_S: s_next.div_s =
					(s_reg.div_s & ~wmask[9:0]) | (writedata[9:0] & wmask[9:0]);
				refswitch_pkg::IDX_IRQ_MSK:
					if (byteenable[0])
						s_next.irq_msk = writedata[4:0];
				default: ;
			endcase
		end
		// Clear only what was returned; a same-cycle event still sets
		if (acc && read && idx == refswitch_pkg::IDX_IRQ_ST)
			clr = s_reg.rdata[4:0];
		s_next.irq_st = (s_reg.irq_st & ~clr) | ev;

		// Pins
		s_next.pins.pd_diff = s_reg.power[refswitch_pkg::PWR_LOOP_PD]
			|| (s_reg.rx_cfg[refswitch_pkg::RX_CMOS_P]
			&& s_reg.rx_cfg[refswitch_pkg::RX_CMOS_S]);
		s_next.pins.pd_se[0] = s_reg.power[refswitch_pkg::PWR_LOOP_PD]
			|| s_reg.buf_cfg[refswitch_pkg::BUF_PD_P]
			|| !s_reg.rx_cfg[refswitch_pkg::RX_CMOS_P];
		s_next.pins.pd_se[1] = s_reg.power[refswitch_pkg::PWR_LOOP_PD]
			|| s_reg.buf_cfg[refswitch_pkg::BUF_PD_S]
			|| !s_reg.rx_cfg[refswitch_pkg::RX_CMOS_S];
		s_next.pins.pd_osc = s_reg.power[refswitch_pkg::PWR_LOOP_PD];
		s_next.pins.oscillator_tuning_output =
			s_reg.rx_cfg[refswitch_pkg::RX_OSC_LO +: 2];
		s_next.pins.holdover = s_reg.state == refswitch_pkg::HOLDOVER;
		s_next.pins.cp_tri = s_next.pins.holdover
			&& !s_reg.misc[refswitch_pkg::MISC_FORCE_MID];
		s_next.pins.cp_mid = s_next.pins.holdover
			&& s_reg.misc[refswitch_pkg::MISC_FORCE_MID];
		if (!s_next.pins.holdover)
			s_next.pins.active_sec =
				s_reg.state == refswitch_pkg::ON_SECONDARY;
		s_next.pins.resync = s_reg.pins.holdover
			&& !s_next.pins.holdover;
		s_next.pins.irq = |(s_reg.irq_st & s_reg.irq_msk);
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			s_reg <= '0;
			s_reg.state <= refswitch_pkg::HOLDOVER;
			s_reg.rx_cfg <= refswitch_pkg::RX_CFG_RST;
			s_reg.buf_cfg <= refswitch_pkg::BUF_CFG_RST;
			s_reg.misc <= refswitch_pkg::MISC_RST;
			s_reg.power <= refswitch_pkg::POWER_RST;
			s_reg.div_p <= refswitch_pkg::DIV_RST;
			s_reg.div_s <= refswitch_pkg::DIV_RST;
			s_reg.waitreq <= 1'b1;
			s_reg.pins.holdover <= 1'b1;
			s_reg.pins.cp_tri <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign readdata         = s_reg.rdata;
	assign waitrequest      = s_reg.waitreq;
	assign diff_rx_pd       = s_reg.pins.pd_diff;
	assign se_buf_pd        = s_reg.pins.pd_se;
	assign osc_rx_pd        = s_reg.pins.pd_osc;
	assign osc_rx_ctrl      = s_reg.pins.oscillator_tuning_output;
	assign cp_tristate      = s_reg.pins.cp_tri;
	assign cp_midsupply     = s_reg.pins.cp_mid;
	assign active_secondary = s_reg.pins.active_sec;
	assign holdover         = s_reg.pins.holdover;
	assign loop_resync      = s_reg.pins.resync;
	assign irq              = s_reg.pins.irq;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic loop_pd;
	logic force_mid;
	logic both_absent;
	assign loop_pd = s_reg.power[refswitch_pkg::PWR_LOOP_PD];
	assign force_mid = s_reg.misc[refswitch_pkg::MISC_FORCE_MID];
	assign both_absent = !s_reg.mon[0].present && !s_reg.mon[1].present;

	sequence seq_on_sec;
		s_reg.state == refswitch_pkg::ON_SECONDARY;
	endsequence
	sequence seq_prim_back;
		s_reg.mon[0].present && s_reg.mon[1].present;
	endsequence
	sequence seq_on_prim;
		s_reg.state == refswitch_pkg::ON_PRIMARY;
	endsequence

	AST_DIFF_PD: assert property (loop_pd && $stable(loop_pd)
		|-> diff_rx_pd)
		else $error("differential receiver on while loop down");
	AST_SE_PD: assert property ($rose(s_reg.buf_cfg[0]) |=> se_buf_pd[0])
		else $error("primary buffer not powered down");
	AST_OSC_PD: assert property ($rose(loop_pd) |=> osc_rx_pd)
		else $error("oscillator receiver not powered down");
	AST_HOLD_IN: assert property (both_absent
		|=> s_reg.state == refswitch_pkg::HOLDOVER ##1 holdover)
		else $error("holdover not entered with both references absent");
	AST_CP_TRI: assert property (holdover && !$past(force_mid)
		|-> cp_tristate && !cp_midsupply)
		else $error("charge pump not tristated in holdover");
	AST_CP_MID: assert property (holdover && $past(force_mid)
		|-> cp_midsupply && !cp_tristate)
		else $error("charge pump not at mid supply");
	AST_REVERT: assert property (seq_on_sec ##0 seq_prim_back
		##0 (s_reg.misc[5:4] == 2'b11)
		|=> s_reg.state == refswitch_pkg::ON_PRIMARY)
		else $error("revertive mode did not return to primary");
	AST_NONREV: assert property (seq_on_sec ##0 seq_prim_back
		##0 (s_reg.misc[5:4] == 2'b10) |=> seq_on_sec)
		else $error("nonrevertive mode left secondary");
	AST_AUTO_SW: assert property (seq_on_prim
		##0 (!s_reg.mon[0].present && s_reg.mon[1].present
		&& s_reg.misc[5]) |=> seq_on_sec ##1 active_secondary)
		else $error("automatic switch to secondary missing");
	AST_RESYNC: assert property ($fell(holdover)
		|-> loop_resync ##1 !loop_resync)
		else $error("resync pulse missing on holdover exit");

endmodule : reference_switchover_holdover

// File: core/refswitch_pkg.sv
// Constants and carrier types of the reference switchover and holdover block.
// Assumes a single 25 MHz system clock; every other rate is counted in it.
package refswitch_pkg;

	// System clock
	localparam int CLK_PERIOD_NS = 40;

	// Register word indices; byte address is four times the index
	localparam logic [9:0] IDX_RX_CFG  = 10'h01A;
	localparam logic [9:0] IDX_BUF_CFG = 10'h01B;
	localparam logic [9:0] IDX_MISC    = 10'h01C;
	localparam logic [9:0] IDX_POWER   = 10'h233;
	localparam logic [9:0] IDX_DIV_P   = 10'h020;
	localparam logic [9:0] IDX_DIV_S   = 10'h021;
	localparam logic [9:0] IDX_STATUS  = 10'h022;
	localparam logic [9:0] IDX_IRQ_ST  = 10'h023;
	localparam logic [9:0] IDX_IRQ_MSK = 10'h024;

	// Field positions
	localparam int RX_OSC_LO      = 0;
	localparam int RX_CMOS_P      = 5;
	localparam int RX_CMOS_S      = 6;
	localparam int BUF_PD_P       = 0;
	localparam int BUF_PD_S       = 1;
	localparam int MISC_MAN_SEL   = 3;
	localparam int MISC_USE_PIN   = 2;
	localparam int MISC_AUTO      = 5;
	localparam int MISC_REVERT    = 4;
	localparam int MISC_FORCE_MID = 6;
	localparam int MISC_INDEP_DIV = 7;
	localparam int PWR_LOOP_PD    = 2;

	// Reset values
	localparam logic [7:0] RX_CFG_RST  = 8'h00;
	localparam logic [7:0] BUF_CFG_RST = 8'h00;
	localparam logic [7:0] MISC_RST    = 8'h00;
	localparam logic [7:0] POWER_RST   = 8'h00;
	localparam logic [9:0] DIV_RST     = 10'h001;

	// Divider ratio bounds
	localparam logic [9:0] DIV_MIN = 10'h001;
	localparam logic [9:0] DIV_MAX = 10'h3FF;

	// Interrupt events
	localparam int IRQ_W      = 5;
	localparam int EV_LOST_P  = 0;
	localparam int EV_LOST_S  = 1;
	localparam int EV_SWITCH  = 2;
	localparam int EV_HOLD_IN = 3;
	localparam int EV_HOLD_EX = 4;

	localparam int WIN_W = 16;
	localparam int HIT_W = 4;

	typedef enum logic [1:0] {ON_PRIMARY, ON_SECONDARY, HOLDOVER} sw_state_t;

	typedef struct packed {
		logic [2:0] sync;
		logic       level;
		logic [9:0] divcnt;
		logic [WIN_W-1:0] win;
		logic       seen;
		logic [HIT_W-1:0] miss;
		logic [HIT_W-1:0] hit;
		logic       present;
	} ref_mon_t;

	typedef struct packed {
		logic       pd_diff;
		logic [1:0] pd_se;
		logic       pd_osc;
		logic [1:0] oscillator_tuning_output;
		logic       cp_tri;
		logic       cp_mid;
		logic       active_sec;
		logic       holdover;
		logic       resync;
		logic       irq;
	} pins_t;

	typedef struct packed {
		ref_mon_t [1:0] mon;
		logic [2:0]  sel_sync;
		logic        sel_level;
		sw_state_t   state;
		logic [7:0]  rx_cfg;
		logic [7:0]  buf_cfg;
		logic [7:0]  misc;
		logic [7:0]  power;
		logic [9:0]  div_p;
		logic [9:0]  div_s;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_msk;
		logic        waitreq;
		logic [31:0] rdata;
		pins_t       pins;
	} state_t;

endpackage : refswitch_pkg

// File: verification/ref_clock_pair.sv
// Behavioural pair of reference clock sources, 320 ns period each.
// Assumes the bench gates each source; a gated source stands still low.
`timescale 1ns/1ps

module ref_clock_pair #(
	parameter int HALF_NS = 160
) (
	// Source enables
	input  wire logic en_p,
	input  wire logic en_s,
	// Reference clocks
	output logic      ref_p,
	output logic      ref_s
);
	initial
	begin
		ref_p = 1'b0;
		forever #(HALF_NS) ref_p = en_p ? ~ref_p : 1'b0;
	end

	// Offset phase so the two sources never share an mclk sample
	initial
	begin
		ref_s = 1'b0;
		#70;
		forever #(HALF_NS) ref_s = en_s ? ~ref_s : 1'b0;
	end
endmodule : ref_clock_pair

// File: verification/reference_switchover_holdover_bench.sv
// Self-checking bench: Avalon-MM register tasks, reference sources, pins.
// Assumes a shortened presence window of 64 mclk cycles in simulation.
`timescale 1ns/1ps

module reference_switchover_holdover_bench;
	logic        mclk;
	logic        rst_n;
	logic [11:0] address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        ref_p;
	logic        ref_s;
	logic        en_p;
	logic        en_s;
	logic        sel_pin;
	logic        diff_rx_pd;
	logic [1:0]  se_buf_pd;
	logic        osc_rx_pd;
	logic [1:0]  osc_rx_ctrl;
	logic        cp_tristate;
	logic        cp_midsupply;
	logic        active_sec;
	logic        holdover;
	logic        loop_resync;
	logic        irq;
	logic [31:0] exp_q[$];
	logic [31:0] rng;
	int          n_mismatch;
	int          comparisons;
	int          cycles;
	int          n_resync;
	wire  [3:0]  pw = {diff_rx_pd, se_buf_pd, osc_rx_pd};
	wire  [3:0]  lp = {holdover, active_sec, cp_tristate, cp_midsupply};

	reference_switchover_holdover #(
		.WINDOW_CYCLES(64),
		.EDGE_COUNT   (4)
	) i_reference_switchover_holdover (
		.mclk                     (mclk),
		.rst_n                    (rst_n),
		.address                  (address),
		.read                     (read),
		.write                    (write),
		.writedata                (writedata),
		.byteenable               (4'hF),
		.readdata                 (readdata),
		.waitrequest              (waitrequest),
		.primary_reference_input  (ref_p),
		.secondary_reference_input(ref_s),
		.ref_select_pin           (sel_pin),
		.diff_rx_pd               (diff_rx_pd),
		.se_buf_pd                (se_buf_pd),
		.osc_rx_pd                (osc_rx_pd),
		.osc_rx_ctrl              (osc_rx_ctrl),
		.cp_tristate              (cp_tristate),
		.cp_midsupply             (cp_midsupply),
		.active_secondary         (active_sec),
		.holdover                 (holdover),
		.loop_resync              (loop_resync),
		.irq                      (irq)
	);

	ref_clock_pair i_ref_clock_pair (
		.en_p (en_p),
		.en_s (en_s),
		.ref_p(ref_p),
		.ref_s(ref_s)
	);

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	// One Avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic [9:0] idx, input logic wr,
		input logic [31:0] d);
		address   <= {idx, 2'b00};
		read      <= !wr;
		write     <= wr;
		writedata <= d;
		// Waitrequest is a flop: look between edges, act on the next rise
		do @(negedge mclk); while (waitrequest !== 1'b0);
		@(posedge mclk);
		read  <= 1'b0;
		write <= 1'b0;
		@(posedge mclk);
	endtask : bus

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		bus(idx, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [9:0] idx, input logic [31:0] e);
		exp_q.push_back(e);
		bus(idx, 1'b0, 32'h0000_0000);
	endtask : rd

	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask : wt

	task automatic done(input string name);
		$display("Test %s finished", name);
	endtask : done

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Outputs are flops; sampled mid-cycle, where they are settled
	always @(negedge mclk)
	begin
		cycles++;
		if (loop_resync === 1'b1)
			n_resync++;
		if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
			chk("readdata", exp_q.pop_front(), readdata);
		if (cycles == 20000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial
	begin
		rst_n = 1'b0;
		address = 12'h000;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		en_p = 1'b0;
		en_s = 1'b0;
		sel_pin = 1'b0;
		rng = 32'h0000_8519;
		wt(16);
		rst_n <= 1'b1;
		wt(3);
		chk("power pins", 4'b0110, pw);
		chk("loop pins", 4'b1010, lp);
		rd(refswitch_pkg::IDX_RX_CFG, 32'h0000_0000);
		rd(refswitch_pkg::IDX_MISC, 32'h0000_0000);
		rd(refswitch_pkg::IDX_POWER, 32'h0000_0000);
		rd(refswitch_pkg::IDX_DIV_P, 32'h0000_0001);
		rng = xs(rng);
		wr(10'h100, rng);
		rd(10'h100, 32'h0000_0000);
		done("reset");

		wr(refswitch_pkg::IDX_POWER, 32'h0000_0004);
		wt(3);
		chk("power pins", 4'b1111, pw);
		wr(refswitch_pkg::IDX_POWER, 32'h0000_0000);
		wr(refswitch_pkg::IDX_RX_CFG, 32'h0000_0062);
		wt(3);
		chk("power pins", 4'b1000, pw);
		chk("oscillator_tuning_output", 2'b10, osc_rx_ctrl);
		wr(refswitch_pkg::IDX_BUF_CFG, 32'h0000_0001);
		wt(3);
		chk("power pins", 4'b1010, pw);
		rd(refswitch_pkg::IDX_RX_CFG, 32'h0000_0062);
		wr(refswitch_pkg::IDX_RX_CFG, 32'h0000_0000);
		wr(refswitch_pkg::IDX_BUF_CFG, 32'h0000_0000);
		wr(refswitch_pkg::IDX_DIV_P, 32'h0000_03FF);
		rd(refswitch_pkg::IDX_DIV_P, 32'h0000_03FF);
		wr(refswitch_pkg::IDX_DIV_P, 32'h0000_0001);
		done("power");

		wr(refswitch_pkg::IDX_MISC, 32'h0000_0020);
		// Primary windows ahead, so holdover exit picks it for sure
		en_p <= 1'b1;
		wt(100);
		en_s <= 1'b1;
		wt(400);
		chk("loop pins", 4'b0000, lp);
		chk("resync", 1, n_resync);
		rd(refswitch_pkg::IDX_STATUS, 32'h0000_0003);
		bus(refswitch_pkg::IDX_IRQ_ST, 1'b0, 32'h0000_0000);
		en_p <= 1'b0;
		wt(400);
		chk("loop pins", 4'b0100, lp);
		chk("irq", 1'b0, irq);
		wr(refswitch_pkg::IDX_IRQ_MSK, 32'h0000_001F);
		wt(2);
		chk("irq", 1'b1, irq);
		rd(refswitch_pkg::IDX_IRQ_ST, 32'h0000_0005);
		wt(2);
		chk("irq", 1'b0, irq);
		en_p <= 1'b1;
		wt(400);
		chk("loop pins", 4'b0100, lp);
		en_s <= 1'b0;
		wt(400);
		chk("loop pins", 4'b0000, lp);
		en_p <= 1'b0;
		wt(400);
		chk("loop pins", 4'b1010, lp);
		wr(refswitch_pkg::IDX_MISC, 32'h0000_0060);
		wt(3);
		chk("loop pins", 4'b1001, lp);
		en_s <= 1'b1;
		wt(400);
		chk("loop pins", 4'b0100, lp);
		chk("resync", 2, n_resync);
		wr(refswitch_pkg::IDX_MISC, 32'h0000_0030);
		en_p <= 1'b1;
		wt(400);
		chk("loop pins", 4'b0000, lp);
		done("automatic");

		wr(refswitch_pkg::IDX_MISC, 32'h0000_0008);
		wt(3);
		chk("loop pins", 4'b0100, lp);
		wr(refswitch_pkg::IDX_MISC, 32'h0000_0004);
		for (int v = 1; v >= 0; v--)
		begin
			sel_pin <= v[0];
			wt(8);
			chk("active sec", v[0], active_sec);
		end
		done("manual");

		rng = xs(rng);
		// Manual primary: order of the two losses cannot move the active bit
		wr(refswitch_pkg::IDX_MISC, 32'h0000_0000);
		wr(refswitch_pkg::IDX_DIV_P, 32'h0000_0028);
		wr(refswitch_pkg::IDX_DIV_S, {30'h0, rng[1:0]} + 32'h0000_0001);
		wt(500);
		rd(refswitch_pkg::IDX_STATUS, 32'h0000_0008);
		wr(refswitch_pkg::IDX_MISC, 32'h0000_00A0);
		wt(500);
		rd(refswitch_pkg::IDX_STATUS, 32'h0000_0006);
		done("dividers");
		give_verdict();
	end
endmodule : reference_switchover_holdover_bench
